// file: src/uhpc_top.v
// uhpc_top.v: host bus-mode decode and modem pin control for a two-channel uart
// assumes host pins arrive asynchronously and the bus-mode strap is static
// What this block does
// R1: mode high: interrupt pin serves channel A only
// R2: control bit 3 drives interrupt enable, user output low
// R3: mode low: channel A pin is open-drain device request
// R4: channel B interrupt pin used only in mode high
// R5: read strobe used in mode high, ignored otherwise
// R6: host drives write strobe in mode high
// R7: mode low: write pin high reads, low writes
// R8: master reset polarity follows bus mode
// R9: software should use interrupt or user output, not both
// R10: ring rising edge raises enabled modem-status interrupt
// R11: control bit 1 drives request-to-send low
// R12: request-to-send high after any reset
// R13: mode low: one chip select, chan_b_sel high picks channel B
// R14: control bit 0 drives terminal-ready low
// R15: bus-mode strap held stable during operation
`timescale 1ns/1ns
`include "uhpc_defs.vh"

module uhpc_top (
    // clock and power-on reset
    input wire core_clk,
    input wire rst,
    // strap and master reset pin
    input wire bus_mode_pin,
    input wire master_reset_pin,
    // host strobes, selects, address and data
    input wire host_rd_strobe_n,
    input wire host_wr_strobe_n,
    input wire chan_a_sel,
    input wire chan_b_sel,
    input wire [2:0] host_addr,
    input wire [7:0] host_wdata,
    // interrupt enables per channel
    input wire [7:0] chan_a_irq_en,
    input wire [7:0] chan_b_irq_en,
    // modem-status flag clear, one pulse per channel
    input wire chan_a_status_clr,
    input wire chan_b_status_clr,
    // ring inputs
    input wire chan_a_ring_in,
    input wire chan_b_ring_in,
    // interrupt pins: output, output enable
    output wire chan_a_irq_out,
    output wire chan_a_irq_oe,
    output wire chan_b_irq_out,
    output wire chan_b_irq_oe,
    // user and modem outputs
    output wire chan_a_user_out,
    output wire chan_b_user_out,
    output wire chan_a_req_send_n,
    output wire chan_b_req_send_n,
    output wire chan_a_term_ready_n,
    output wire chan_b_term_ready_n,
    // decoded host access status, device reset and modem-control registers
    output reg host_rd_pulse,
    output reg host_wr_pulse,
    output reg host_chan_b,
    output wire device_reset,
    output wire [7:0] chan_a_modem_ctrl,
    output wire [7:0] chan_b_modem_ctrl
);
    // two-stage synchronisers for every pin input
    reg [7:0] sync1_reg;
    reg [7:0] sync2_reg;
    reg [7:0] sync_d_reg; // data captured alongside strobes
    reg [2:0] addr_reg; // address captured alongside strobes
    reg mode_reg; // strap level, resampled every cycle after reset release
    reg strobe_prev_reg; // previous access-active level
    reg [10:0] bus_s1_reg; // address and data, first stage
    reg [10:0] bus_s2_reg; // address and data, second stage
    reg pin_reset_reg; // decoded master reset, registered
    // synchronised pin levels
    wire mreset_sync;
    wire mode_now;
    wire rd_n_s;
    wire wr_n_s;
    wire sel_a_s;
    wire sel_b_s;
    wire ring_a_s;
    wire ring_b_s;
    wire pin_reset_next; // master reset decoded for the current mode
    // access decode
    wire sel_any;
    wire acc_active;
    wire acc_is_wr;
    wire acc_chan_b;
    wire a_wr;
    wire b_wr;
    wire a_drive;
    wire b_drive;

    // pin synchroniser: first stage feeds only the second
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= 8'hFF;
            sync2_reg <= 8'hFF;
        end else begin
            sync1_reg <= {bus_mode_pin, master_reset_pin, host_rd_strobe_n,
                host_wr_strobe_n, chan_a_sel, chan_b_sel, chan_a_ring_in, chan_b_ring_in};
            sync2_reg <= sync1_reg;
        end
    end

    // host address and data ride their own two-stage path; the strobes lag by the
    // same two edges, so the word captured is the one set up with the strobe
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus_s1_reg <= 11'h000;
            bus_s2_reg <= 11'h000;
        end else begin
            bus_s1_reg <= {host_addr, host_wdata};
            bus_s2_reg <= bus_s1_reg;
        end
    end

    assign mode_now = sync2_reg[7];
    assign mreset_sync = sync2_reg[6];
    assign rd_n_s = sync2_reg[5];
    assign wr_n_s = sync2_reg[4];
    assign sel_a_s = sync2_reg[3];
    assign sel_b_s = sync2_reg[2];
    // ring pins are active low; a rise to logic high is the interrupt edge
    assign ring_a_s = sync2_reg[1];
    assign ring_b_s = sync2_reg[0];

    // strap sampled continuously; held static by the board so no mid-run change
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mode_reg <= 1'b1; // open strap reads high
        end else begin
            mode_reg <= mode_now; // see R15
        end
    end

    // master reset polarity depends on bus mode
    assign pin_reset_next = mode_reg ? mreset_sync : ~mreset_sync; // see R8

    // registered so the combined reset cannot glitch when strap and pin move together;
    // costs one edge of extra reset latency
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_reset_reg <= 1'b1; // held in reset until the strap is known
        end else begin
            pin_reset_reg <= pin_reset_next; // see R8
        end
    end

    // power-on reset or the decoded master reset pin
    assign device_reset = rst | pin_reset_reg;

    // chip selects are active low in both modes; in mode low chan_b_sel high picks channel B
    assign sel_any = mode_reg ? (~sel_a_s | ~sel_b_s) : ~sel_a_s; // see R13
    // mode high: separate strobes; mode low: chip select plus direction line
    assign acc_active = mode_reg ? sel_any & (~rd_n_s | ~wr_n_s) // see R5
        : sel_any; // see R5
    // write strobe low in mode high, direction line low in mode low: both mean write
    assign acc_is_wr = mode_reg ? ~wr_n_s : ~wr_n_s; // see R6 see R7
    assign acc_chan_b = mode_reg ? ~sel_b_s : sel_b_s; // see R13

    // capture data with the access and emit one pulse per access start
    always @(posedge core_clk or posedge device_reset) begin
        if (device_reset) begin
            strobe_prev_reg <= 1'b0;
            host_rd_pulse <= 1'b0;
            host_wr_pulse <= 1'b0;
            host_chan_b <= 1'b0;
            sync_d_reg <= 8'h00;
            addr_reg <= 3'h0;
        end else begin
            strobe_prev_reg <= acc_active;
            host_rd_pulse <= acc_active & ~strobe_prev_reg & ~acc_is_wr; // see R7
            host_wr_pulse <= acc_active & ~strobe_prev_reg & acc_is_wr; // see R7
            if (acc_active & ~strobe_prev_reg) begin
                host_chan_b <= acc_chan_b;
                sync_d_reg <= bus_s2_reg[7:0];
                addr_reg <= bus_s2_reg[10:8];
            end
        end
    end

    // modem-control write decode per channel
    assign a_wr = host_wr_pulse & ~host_chan_b & (addr_reg == `UHPC_MC_OFFSET);
    assign b_wr = host_wr_pulse & host_chan_b & (addr_reg == `UHPC_MC_OFFSET);

    uhpc_chan u_chan_a (
        .core_clk(core_clk),
        .rst(device_reset),
        .mc_wr(a_wr),
        .mc_wdata(sync_d_reg),
        .modem_irq_en(chan_a_irq_en[`UHPC_IE_MODEM_BIT]),
        .ring_clr(chan_a_status_clr),
        .ring_sync(ring_a_s),
        .modem_ctrl_reg(chan_a_modem_ctrl),
        .ring_event(),
        .irq_drive(a_drive),
        .user_out(chan_a_user_out),
        .req_send_n(chan_a_req_send_n),
        .term_ready_n(chan_a_term_ready_n)
    );

    uhpc_chan u_chan_b (
        .core_clk(core_clk),
        .rst(device_reset),
        .mc_wr(b_wr),
        .mc_wdata(sync_d_reg),
        .modem_irq_en(chan_b_irq_en[`UHPC_IE_MODEM_BIT]),
        .ring_clr(chan_b_status_clr),
        .ring_sync(ring_b_s),
        .modem_ctrl_reg(chan_b_modem_ctrl),
        .ring_event(),
        .irq_drive(b_drive),
        .user_out(chan_b_user_out),
        .req_send_n(chan_b_req_send_n),
        .term_ready_n(chan_b_term_ready_n)
    );

    // mode high: channel A pin driven active-high while its out2 bit is set
    // mode low: open-drain low for any channel's pending request
    assign chan_a_irq_out = mode_reg ? a_drive : 1'b0; // see R1 see R3
    assign chan_a_irq_oe = mode_reg ? chan_a_modem_ctrl[`UHPC_MC_OUT2_BIT] // see R2
        : (a_drive | b_drive); // see R3
    // channel B pin floats entirely when the strap is low
    assign chan_b_irq_out = mode_reg ? b_drive : 1'b0; // see R4
    assign chan_b_irq_oe = mode_reg & chan_b_modem_ctrl[`UHPC_MC_OUT2_BIT]; // see R4
endmodule // uhpc_top

// file: inc/uhpc_defs.vh
// uhpc_defs.vh: bit positions, width, reset value and write offset for the host pin control block
// assumes inclusion by bare name from design files; definitions only
`ifndef UHPC_DEFS_VH
`define UHPC_DEFS_VH

// modem-control bit positions
`define UHPC_MC_TERM_READY_BIT 0
`define UHPC_MC_REQ_SEND_BIT 1
`define UHPC_MC_OUT2_BIT 3
// modem-control width and reset value
`define UHPC_MC_WIDTH 8
`define UHPC_MC_RESET 8'h00
// modem-control write offset within a channel (register index)
`define UHPC_MC_OFFSET 3'h4
// interrupt-enable bit for modem-status source
`define UHPC_IE_MODEM_BIT 3

`endif

// file: src/uhpc_chan.v
// uhpc_chan.v: one channel's modem-control register, modem outputs and ring-edge detect
// assumes ring input is already synchronised to core_clk and writes are one-cycle pulses
`timescale 1ns/1ns
`include "uhpc_defs.vh"

module uhpc_chan (
    // clock and reset
    input wire core_clk,
    input wire rst,
    // register write
    input wire mc_wr,
    input wire [7:0] mc_wdata,
    input wire modem_irq_en,
    input wire ring_clr,
    // synchronised ring input
    input wire ring_sync,
    // outputs
    output wire [7:0] modem_ctrl_reg,
    output reg ring_event,
    output wire irq_drive,
    output wire user_out,
    output wire req_send_n,
    output wire term_ready_n
);
    reg [7:0] mc_reg; // modem-control storage
    reg ring_prev_reg; // last synchronised ring level
    reg ring_flag_reg; // sticky modem-status interrupt

    assign modem_ctrl_reg = mc_reg;

    // register writes; reset clears all bits so modem outputs idle high
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mc_reg <= `UHPC_MC_RESET; // see R12 see R14
        end else if (mc_wr) begin
            mc_reg <= mc_wdata;
        end
    end

    // rising edge of ring raises a status flag when the modem interrupt enable is set; a set beats a same-cycle clear
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            // matches the synchroniser's reset level, so no false edge follows reset
            ring_prev_reg <= 1'b1;
            ring_flag_reg <= 1'b0;
            ring_event <= 1'b0;
        end else begin
            ring_prev_reg <= ring_sync;
            ring_event <= ring_sync & ~ring_prev_reg;
            if (ring_sync & ~ring_prev_reg & modem_irq_en) begin
                ring_flag_reg <= 1'b1; // see R10
            end else if (ring_clr) begin
                ring_flag_reg <= 1'b0;
            end
        end
    end

    // one bit steers both interrupt drive and user output, so software picks one use
    assign irq_drive = mc_reg[`UHPC_MC_OUT2_BIT] & ring_flag_reg; // see R2
    assign user_out = ~mc_reg[`UHPC_MC_OUT2_BIT]; // see R2
    assign req_send_n = ~mc_reg[`UHPC_MC_REQ_SEND_BIT]; // see R11
    assign term_ready_n = ~mc_reg[`UHPC_MC_TERM_READY_BIT]; // see R14
endmodule // uhpc_chan

// file: sim/uhpc_top_properties.sv
// uhpc_top_properties.sv: port checker bound into uhpc_top
// assumes bus_mode_pin only moves while a reset is held
`timescale 1ns/1ns
module uhpc_top_props (
    // clock and combined reset
    input wire core_clk,
    input wire device_reset,
    // host side
    input wire bus_mode_pin,
    input wire [2:0] host_addr,
    input wire [7:0] host_wdata,
    input wire host_wr_pulse,
    input wire host_chan_b,
    input wire [7:0] chan_a_irq_en,
    input wire chan_a_ring_in,
    // modem side
    input wire chan_a_irq_out,
    input wire chan_a_irq_oe,
    input wire chan_b_irq_oe,
    input wire chan_a_user_out,
    input wire chan_a_req_send_n,
    input wire chan_b_req_send_n,
    input wire chan_a_term_ready_n,
    input wire [7:0] chan_a_modem_ctrl
);
    // cycles since reset; mode register needs 3 edges to follow the strap
    reg [2:0] up_reg;
    wire ok = up_reg == 3'h7;
    always @(posedge core_clk or posedge device_reset) begin
        if (device_reset)
            up_reg <= 3'h0;
        else if (!ok)
            up_reg <= up_reg + 3'h1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (device_reset);
    rts_idle_a: assert property ($fell(device_reset) |-> chan_a_req_send_n &&
        chan_b_req_send_n && chan_a_term_ready_n) else $error("modem out low after reset");
    rts_follow_a: assert property (chan_a_req_send_n == !chan_a_modem_ctrl[1])
        else $error("req send wrong");
    dtr_follow_a: assert property (chan_a_term_ready_n == !chan_a_modem_ctrl[0])
        else $error("term ready wrong");
    user_out_a: assert property (chan_a_user_out == !chan_a_modem_ctrl[3])
        else $error("user out wrong");
    irq_a_en_a: assert property (ok && bus_mode_pin |->
        chan_a_irq_oe == chan_a_modem_ctrl[3]) else $error("irq a enable wrong");
    irq_b_off_a: assert property (ok && !bus_mode_pin |-> !chan_b_irq_oe)
        else $error("irq b driven");
    irq_od_low_a: assert property (ok && !bus_mode_pin && chan_a_irq_oe |->
        !chan_a_irq_out) else $error("open drain drives high");
    wr_single_a: assert property (host_wr_pulse |=> !host_wr_pulse)
        else $error("write pulse long");
    mc_load_a: assert property (host_wr_pulse && host_addr == 3'h4 && !host_chan_b
        |=> chan_a_modem_ctrl == $past(host_wdata)) else $error("write lost");
    ring_irq_a: assert property (ok && bus_mode_pin && chan_a_modem_ctrl[3]
        && chan_a_irq_en[3] && $rose(chan_a_ring_in) |-> ##[1:5] chan_a_irq_out)
        else $error("no ring irq");
    cover property (host_wr_pulse && host_chan_b);
    cover property (ok && !bus_mode_pin && chan_a_irq_oe);
    cover property ($rose(chan_a_irq_out));
endmodule // uhpc_top_props
bind uhpc_top uhpc_top_props u_props (.core_clk(core_clk), .device_reset(device_reset),
    .bus_mode_pin(bus_mode_pin), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_wr_pulse(host_wr_pulse), .host_chan_b(host_chan_b), .chan_a_irq_en(chan_a_irq_en),
    .chan_a_ring_in(chan_a_ring_in), .chan_a_irq_out(chan_a_irq_out),
    .chan_a_irq_oe(chan_a_irq_oe), .chan_b_irq_oe(chan_b_irq_oe),
    .chan_a_user_out(chan_a_user_out), .chan_a_req_send_n(chan_a_req_send_n),
    .chan_b_req_send_n(chan_b_req_send_n), .chan_a_term_ready_n(chan_a_term_ready_n),
    .chan_a_modem_ctrl(chan_a_modem_ctrl));

// file: sim/uhpc_modem_model.sv
// uhpc_modem_model.sv: modem ring line and pulled-up interrupt wire
// assumes ring_go comes from the bench, synchronous to core_clk
`timescale 1ns/1ns
module uhpc_modem_model (
    // control
    input wire core_clk,
    input wire ring_go,
    // interrupt pin from the device
    input wire irq_out,
    input wire irq_oe,
    // far-side view
    output reg ring,
    output wire irq_wire
);
    // released pin floats up through the board pull-up
    assign irq_wire = irq_oe ? irq_out : 1'b1;
    // ring line rises to the idle level one edge after the request
    always @(posedge core_clk) begin
        ring <= ring_go;
    end
endmodule // uhpc_modem_model

// file: sim/uhpc_top_tb.sv
// uhpc_top_tb.sv: self-checking bench for uhpc_top
// assumes the checker is bound in and the modem model sits on each ring pin
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
    $display("wrong value t=%0t %h %h", $time, a, b); end end
module uhpc_top_tb;
    reg core_clk = 0, rst = 1, bus_mode_pin = 1, master_reset_pin = 0;
    reg host_rd_strobe_n = 1, host_wr_strobe_n = 1, chan_a_sel = 1, chan_b_sel = 1;
    reg [2:0] host_addr = 3'h4;
    reg [7:0] host_wdata = 8'h00, chan_a_irq_en = 8'h08, chan_b_irq_en = 8'h08;
    reg chan_a_status_clr = 0, chan_b_status_clr = 0, go_a = 0, go_b = 0;
    wire chan_a_ring_in, chan_b_ring_in, chan_a_irq_out, chan_a_irq_oe, chan_b_irq_out;
    wire chan_b_irq_oe, chan_a_user_out, chan_b_user_out, chan_a_req_send_n, wire_a;
    wire chan_b_req_send_n, chan_a_term_ready_n, chan_b_term_ready_n, wire_b;
    wire host_rd_pulse, host_wr_pulse, host_chan_b, device_reset;
    wire [7:0] chan_a_modem_ctrl, chan_b_modem_ctrl;
    integer failures = 0, total_checks = 0;
    always #20 core_clk = !core_clk;
    uhpc_top u_uhpc_top (.core_clk(core_clk), .rst(rst), .bus_mode_pin(bus_mode_pin),
        .master_reset_pin(master_reset_pin), .host_rd_strobe_n(host_rd_strobe_n),
        .host_wr_strobe_n(host_wr_strobe_n), .chan_a_sel(chan_a_sel), .chan_b_sel(chan_b_sel),
        .host_addr(host_addr), .host_wdata(host_wdata), .chan_a_irq_en(chan_a_irq_en),
        .chan_b_irq_en(chan_b_irq_en), .chan_a_status_clr(chan_a_status_clr),
        .chan_b_status_clr(chan_b_status_clr), .chan_a_ring_in(chan_a_ring_in),
        .chan_b_ring_in(chan_b_ring_in), .chan_a_irq_out(chan_a_irq_out),
        .chan_a_irq_oe(chan_a_irq_oe), .chan_b_irq_out(chan_b_irq_out),
        .chan_b_irq_oe(chan_b_irq_oe), .chan_a_user_out(chan_a_user_out),
        .chan_b_user_out(chan_b_user_out), .chan_a_req_send_n(chan_a_req_send_n),
        .chan_b_req_send_n(chan_b_req_send_n), .chan_a_term_ready_n(chan_a_term_ready_n),
        .chan_b_term_ready_n(chan_b_term_ready_n), .host_rd_pulse(host_rd_pulse),
        .host_wr_pulse(host_wr_pulse), .host_chan_b(host_chan_b), .device_reset(device_reset),
        .chan_a_modem_ctrl(chan_a_modem_ctrl), .chan_b_modem_ctrl(chan_b_modem_ctrl));
    uhpc_modem_model u_modem_a (.core_clk(core_clk), .ring_go(go_a), .irq_out(chan_a_irq_out),
        .irq_oe(chan_a_irq_oe), .ring(chan_a_ring_in), .irq_wire(wire_a));
    uhpc_modem_model u_modem_b (.core_clk(core_clk), .ring_go(go_b), .irq_out(chan_b_irq_out),
        .irq_oe(chan_b_irq_oe), .ring(chan_b_ring_in), .irq_wire(wire_b));
    // reset with strap set; pin reset idles at its inactive level
    task reset_in(input m);
        @(posedge core_clk);
        rst <= 1;
        bus_mode_pin <= m;
        master_reset_pin <= !m;
        go_a <= 0;
        go_b <= 0;
        repeat (2) @(posedge core_clk);
        rst <= 0;
        repeat (8) @(posedge core_clk);
        `CHK({chan_a_req_send_n, chan_b_term_ready_n, chan_b_user_out}, 3'h7)
    endtask
    // one host access; w=1 write, else read; bounded wait for the decoded pulse
    task access(input b, input w, input [7:0] d);
        integer i;
        @(posedge core_clk);
        host_wdata <= d;
        if (bus_mode_pin) begin
            if (b) chan_b_sel <= 0; else chan_a_sel <= 0;
            if (w) begin
                host_wr_strobe_n <= 0;
            end else begin
                host_rd_strobe_n <= 0;
            end
        end else begin
            chan_a_sel <= 0;
            chan_b_sel <= b;
            host_wr_strobe_n <= !w;
        end
        for (i = 0; i < 8 && (w ? !host_wr_pulse : !host_rd_pulse); i++) @(negedge core_clk);
        `CHK({i < 8, host_chan_b}, {1'b1, b})
        @(posedge core_clk);
        chan_a_sel <= 1;
        chan_b_sel <= bus_mode_pin;
        host_wr_strobe_n <= 1;
        host_rd_strobe_n <= 1;
        repeat (4) @(posedge core_clk);
    endtask
    // separate-strobe mode: modem bits, interrupt enables, ring event on channel b
    task mode_high_case;
        reset_in(1);
        access(0, 1, 8'h0B);
        `CHK({chan_a_req_send_n, chan_a_term_ready_n, chan_a_user_out}, 3'h0)
        `CHK({chan_a_irq_oe, chan_b_irq_oe, chan_b_req_send_n}, 3'h5)
        access(1, 1, 8'h08);
        go_a <= 1;
        go_b <= 1;
        repeat (6) @(posedge core_clk);
        `CHK({chan_b_irq_oe, chan_b_irq_out, chan_b_user_out}, 3'h6)
        `CHK({chan_a_irq_out, chan_a_irq_oe}, 2'h3)
        chan_b_status_clr <= 1;
        @(posedge core_clk);
        chan_b_status_clr <= 0;
        repeat (2) @(posedge core_clk);
        `CHK({chan_b_irq_out, chan_b_irq_oe}, 2'h1)
        access(0, 0, 8'h00);
        access(0, 1, 8'h00);
        `CHK({chan_a_irq_oe, chan_a_modem_ctrl}, 9'h000)
        master_reset_pin <= 1;
        repeat (4) @(posedge core_clk);
        `CHK({device_reset, chan_b_modem_ctrl}, 9'h100)
    endtask
    // single r/w-line mode: channel pick by chan_b_sel level, write offset by address, open-drain device interrupt
    task mode_low_case;
        reset_in(0);
        access(1, 1, 8'h02);
        `CHK({chan_b_req_send_n, chan_a_req_send_n}, 2'h1)
        access(0, 1, 8'h08);
        host_addr <= 3'h5;
        access(0, 1, 8'hFF);
        `CHK(chan_a_modem_ctrl, 8'h08)
        host_addr <= 3'h4;
        access(1, 0, 8'h00);
        go_a <= 1;
        repeat (6) @(posedge core_clk);
        `CHK({wire_a, chan_a_irq_oe, chan_b_irq_oe}, 3'h2)
        master_reset_pin <= 0;
        repeat (4) @(posedge core_clk);
        `CHK({device_reset, chan_a_modem_ctrl, chan_b_req_send_n}, 10'h201)
    endtask
    task stop_test;
        if (failures == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200000;
        failures++;
        stop_test;
    end
    initial begin
        mode_high_case;
        mode_low_case;
        stop_test;
    end
endmodule // uhpc_top_tb
